// ### hdl/fifo_port_flags.sv
// dual-port bus-matching fifo: port gating, flags and port b sizing, sampled on core_clk
//
// Functional notes
// - both data ports are 36-bit bidirectional
// - almost_empty_n low when count <= offset
// - almost_full_n low when free <= threshold
// - almost_empty_n updated only on port b edges
// - almost_full_n updated only on port a edges
// - endian high at reset: big-endian lane order
// - endian low at reset: little-endian lane order
// - after reset pin low selects fall-through mode
// - bus_width_match picks long or narrow port b
// - width, size, endian jointly set port b
// - port a clock free-running, any phase to b
// - port b clock free-running and independent
// - port a flags change only on a edges
// - port b flags change only on b edges
// - port a access only while select low
// - port a data high-z while select high
// - port b access only while select low
// - port b data high-z while select high
// - standard mode: low flag means fifo empty
// - fall-through mode: flag means output word valid
// - transfers also need the qualify input high
// - full flag means full or input ready
// - data flows only from port a to b
//
// Design decisions made here: strobed register access and the register offsets.
module fifo_port_flags
	import fifo_port_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// port a pins
	input wire logic port_a_clock,
	input wire logic port_a_select_n,
	input wire logic port_a_qualify,
	input wire logic port_a_write,
	input wire logic [fifo_port_pkg::DATA_W-1:0] port_a_data_i,
	output logic [fifo_port_pkg::DATA_W-1:0] port_a_data_o,
	output logic port_a_data_oe,
	output logic full_inready_flag,
	output logic almost_full_n,
	// port b pins
	input wire logic port_b_clock,
	input wire logic port_b_select_n,
	input wire logic port_b_qualify,
	input wire logic port_b_write,
	input wire logic [fifo_port_pkg::DATA_W-1:0] port_b_data_i,
	output logic [fifo_port_pkg::DATA_W-1:0] port_b_data_o,
	output logic port_b_data_oe,
	output logic empty_outvalid_flag,
	output logic almost_empty_n,
	// configuration straps
	input wire logic endian_or_timing_select,
	input wire logic bus_width_match,
	input wire logic narrow_width_select,
	// register port
	input wire logic [fifo_port_pkg::REG_ADDR_W-1:0] reg_addr,
	input wire logic [fifo_port_pkg::REG_DATA_W-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [fifo_port_pkg::REG_DATA_W-1:0] reg_rdata
);
	import fifo_port_pkg::*;

	// two-flop synchronisers plus a third stage for edge detection
	port_ctl_t a_s1_r, a_s2_r, a_s3_r;
	port_ctl_t b_s1_r, b_s2_r, b_s3_r;
	logic [DATA_W-1:0] a_dat_s1_r, a_dat_s2_r;
	logic [2:0] strap_s1_r, strap_s2_r;
	logic cfg_loaded_r;
	logic big_endian_r;

	logic a_edge, b_edge, a_wr, b_rd;
	logic [PTR_W-1:0] wr_ptr_r, rd_ptr_r, mem_cnt, occ, free_cnt;
	logic full;
	logic [DATA_W-1:0] mem [DEPTH];
	logic [DATA_W-1:0] stage_r;
	logic stage_v_r;
	logic [1:0] lane_r, last_lane;
	port_cfg_t cfg;

	logic [PTR_W-1:0] ae_offset_r, af_thresh_r;
	logic [DATA_W-1:0] port_b_dout_r;
	logic port_a_oe_r, port_b_oe_r;
	logic full_inready_flag_r, af_n_r, empty_outvalid_flag_r, ae_n_r;
	logic [REG_DATA_W-1:0] rdata_r;

	// port b writes would target the mailbox, which is not built here
	logic unused_b_data;
	assign unused_b_data = ^port_b_data_i;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			a_s1_r <= '0;
			a_s2_r <= '0;
			a_s3_r <= '0;
			b_s1_r <= '0;
			b_s2_r <= '0;
			b_s3_r <= '0;
			a_dat_s1_r <= '0;
			a_dat_s2_r <= '0;
		end else begin
			a_s1_r <= '{port_a_clock, port_a_select_n, port_a_qualify, port_a_write};
			a_s2_r <= a_s1_r;
			a_s3_r <= a_s2_r;
			b_s1_r <= '{port_b_clock, port_b_select_n, port_b_qualify, port_b_write};
			b_s2_r <= b_s1_r;
			b_s3_r <= b_s2_r;
			a_dat_s1_r <= port_a_data_i;
			a_dat_s2_r <= a_dat_s1_r;
		end
	end

	// strap flops take no reset: the level held while reset is low
	// must already stand in the second stage when reset is released
	always_ff @(posedge core_clk) begin
		strap_s1_r <= {endian_or_timing_select, bus_width_match, narrow_width_select};
		strap_s2_r <= strap_s1_r;
	end

	// endian is caught once, at release, from the level held through reset
	// later changes of the pin only select the timing mode
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg_loaded_r <= 1'b0;
			big_endian_r <= 1'b0;
		end else if (!cfg_loaded_r && a_s3_r.clock == a_s2_r.clock && strap_s2_r == strap_s1_r) begin
			cfg_loaded_r <= 1'b1;
			big_endian_r <= strap_s2_r[2];
		end
	end

	// pin is the timing mode once reset is over; partner keeps it static
	always_comb begin
		cfg.big_endian = big_endian_r;
		cfg.fall_through = cfg_loaded_r & ~strap_s2_r[2];
		cfg.match = strap_s2_r[1];
		cfg.narrow = strap_s2_r[0];
	end

	// port b width from match and narrow selects
	always_comb begin
		if (!cfg.match) begin
			last_lane = LAST_LONG;
		end else if (cfg.narrow) begin
			last_lane = LAST_BYTE;
		end else begin
			last_lane = LAST_WORD;
		end
	end

	// edges of the free-running port clocks, seen after synchronisation
	assign a_edge = a_s2_r.clock & ~a_s3_r.clock;
	assign b_edge = b_s2_r.clock & ~b_s3_r.clock;
	assign a_wr = a_edge & ~a_s2_r.select_n & a_s2_r.qualify & a_s2_r.write & cfg_loaded_r;
	assign b_rd = b_edge & ~b_s2_r.select_n & b_s2_r.qualify & ~b_s2_r.write & cfg_loaded_r;

	assign mem_cnt = wr_ptr_r - rd_ptr_r;
	assign full = mem_cnt == PTR_W'(DEPTH);
	assign occ = mem_cnt + PTR_W'(stage_v_r);
	assign free_cnt = PTR_W'(DEPTH) - mem_cnt;

	// selects one lane of a stored word for the narrow port b widths
	function automatic logic [DATA_W-1:0] lane_pick(input logic [DATA_W-1:0] w, input logic [1:0] lane,
			input logic [1:0] last, input logic big);
		logic [1:0] idx;
		logic [DATA_W-1:0] res;
		idx = big ? 2'(last - lane) : lane;
		res = w;
		if (last == LAST_WORD) begin
			res = idx[0] ? {{HALF_W{1'b0}}, w[DATA_W-1:HALF_W]} : {{HALF_W{1'b0}}, w[HALF_W-1:0]};
		end else if (last == LAST_BYTE) begin
			case (idx)
				2'h0: res = {{(DATA_W-BYTE_W){1'b0}}, w[BYTE_W-1:0]};
				2'h1: res = {{(DATA_W-BYTE_W){1'b0}}, w[2*BYTE_W-1:BYTE_W]};
				2'h2: res = {{(DATA_W-BYTE_W){1'b0}}, w[3*BYTE_W-1:2*BYTE_W]};
				default: res = {{(DATA_W-BYTE_W){1'b0}}, w[DATA_W-1:3*BYTE_W]};
			endcase
		end
		return res;
	endfunction

	// write side: full fifo silently drops the word
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_ptr_r <= '0;
		end else if (a_wr && !full) begin
			wr_ptr_r <= wr_ptr_r + PTR_W'(1);
		end
	end

	always_ff @(posedge core_clk) begin
		if (a_wr && !full) begin
			mem[wr_ptr_r[PTR_W-2:0]] <= a_dat_s2_r;
		end
	end

	// read side: stage holds a word whose lanes are still being read out
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_ptr_r <= '0;
			stage_r <= '0;
			stage_v_r <= 1'b0;
			lane_r <= '0;
			port_b_dout_r <= '0;
		end else if (cfg.fall_through) begin
			if (b_rd && stage_v_r) begin
				if (lane_r != last_lane) begin
					lane_r <= lane_r + 2'h1;
					port_b_dout_r <= lane_pick(stage_r, lane_r + 2'h1, last_lane, cfg.big_endian);
				end else if (mem_cnt != '0) begin
					stage_r <= mem[rd_ptr_r[PTR_W-2:0]];
					rd_ptr_r <= rd_ptr_r + PTR_W'(1);
					lane_r <= '0;
					port_b_dout_r <= lane_pick(mem[rd_ptr_r[PTR_W-2:0]], 2'h0, last_lane, cfg.big_endian);
				end else begin
					stage_v_r <= 1'b0;
					lane_r <= '0;
				end
			end else if (b_edge && !stage_v_r && mem_cnt != '0) begin
				// first word falls through with no read request
				stage_r <= mem[rd_ptr_r[PTR_W-2:0]];
				stage_v_r <= 1'b1;
				rd_ptr_r <= rd_ptr_r + PTR_W'(1);
				lane_r <= '0;
				port_b_dout_r <= lane_pick(mem[rd_ptr_r[PTR_W-2:0]], 2'h0, last_lane, cfg.big_endian);
			end
		end else if (b_rd) begin
			if (stage_v_r) begin
				port_b_dout_r <= lane_pick(stage_r, lane_r, last_lane, cfg.big_endian);
				if (lane_r == last_lane) begin
					stage_v_r <= 1'b0;
					lane_r <= '0;
				end else begin
					lane_r <= lane_r + 2'h1;
				end
			end else if (mem_cnt != '0) begin
				// standard mode needs a read to reach the first word
				port_b_dout_r <= lane_pick(mem[rd_ptr_r[PTR_W-2:0]], 2'h0, last_lane, cfg.big_endian);
				rd_ptr_r <= rd_ptr_r + PTR_W'(1);
				if (last_lane != LAST_LONG) begin
					stage_r <= mem[rd_ptr_r[PTR_W-2:0]];
					stage_v_r <= 1'b1;
					lane_r <= 2'h1;
				end
			end
		end
	end

	// port a flags move only with port a edges
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			full_inready_flag_r <= 1'b0;
			af_n_r <= 1'b1;
		end else if (a_edge) begin
			full_inready_flag_r <= cfg_loaded_r & ~full;
			af_n_r <= ~(free_cnt <= af_thresh_r);
		end
	end

	// port b flags move only with port b edges
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			empty_outvalid_flag_r <= 1'b0;
			ae_n_r <= 1'b0;
		end else if (b_edge) begin
			empty_outvalid_flag_r <= cfg.fall_through ? stage_v_r : (occ != '0);
			ae_n_r <= ~(occ <= ae_offset_r);
		end
	end

	// bus drivers follow the selects; port a has no fifo data to return
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			port_a_oe_r <= 1'b0;
			port_b_oe_r <= 1'b0;
		end else begin
			port_a_oe_r <= ~a_s2_r.select_n & ~a_s2_r.write;
			port_b_oe_r <= ~b_s2_r.select_n & ~b_s2_r.write;
		end
	end

	// register port: thresholds steer the almost flags
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ae_offset_r <= RST_AE_OFFSET;
			af_thresh_r <= RST_AF_THRESH;
		end else if (reg_write) begin
			if (reg_addr == OFS_AE_OFFSET) begin
				ae_offset_r <= reg_wdata[PTR_W-1:0];
			end
			if (reg_addr == OFS_AF_THRESH) begin
				af_thresh_r <= reg_wdata[PTR_W-1:0];
			end
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_r <= '0;
		end else if (reg_read) begin
			rdata_r <= '0;
			case (reg_addr)
				OFS_AE_OFFSET: rdata_r[PTR_W-1:0] <= ae_offset_r;
				OFS_AF_THRESH: rdata_r[PTR_W-1:0] <= af_thresh_r;
				OFS_CONFIG: begin
					rdata_r[CFG_BIG_POS] <= cfg.big_endian;
					rdata_r[CFG_FALL_THROUGH_MODE_POS] <= cfg.fall_through;
					rdata_r[CFG_NARROW_POS] <= cfg.narrow;
					rdata_r[CFG_MATCH_POS] <= cfg.match;
				end
				OFS_STATUS: begin
					rdata_r[STS_COUNT_POS +: PTR_W] <= mem_cnt;
					rdata_r[STS_STAGE_POS] <= stage_v_r;
					rdata_r[STS_FULL_POS] <= full;
				end
				default: rdata_r <= '0;
			endcase
		end else begin
			// read data stands only in the cycle after the strobe
			rdata_r <= '0;
		end
	end

	// port a read returns zeros: the mailbox is not built
	assign port_a_data_o = '0;
	assign port_a_data_oe = port_a_oe_r;
	assign port_b_data_o = port_b_dout_r;
	assign port_b_data_oe = port_b_oe_r;
	assign full_inready_flag = full_inready_flag_r;
	assign almost_full_n = af_n_r;
	assign empty_outvalid_flag = empty_outvalid_flag_r;
	assign almost_empty_n = ae_n_r;
	assign reg_rdata = rdata_r;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	chk_af_on_a_edge: assert property (!$past(a_edge) |-> $stable(almost_full_n) && $stable(full_inready_flag))
		else $error("port a flag moved without a port a edge");
	chk_ae_on_b_edge: assert property (!$past(b_edge) |-> $stable(almost_empty_n) && $stable(empty_outvalid_flag))
		else $error("port b flag moved without a port b edge");
	chk_ae_level: assert property (b_edge |=> almost_empty_n == ($past(occ) > $past(ae_offset_r)))
		else $error("almost empty level wrong");
	chk_af_level: assert property (a_edge |=> almost_full_n == ($past(free_cnt) > $past(af_thresh_r)))
		else $error("almost full level wrong");
	chk_a_hiz: assert property ($past(a_s2_r.select_n) |-> !port_a_data_oe)
		else $error("port a driven while deselected");
	chk_b_hiz: assert property ($past(b_s2_r.select_n) |-> !port_b_data_oe)
		else $error("port b driven while deselected");
	chk_a_gating: assert property ((a_s2_r.select_n || !a_s2_r.qualify) |=> wr_ptr_r == $past(wr_ptr_r))
		else $error("port a wrote while not selected");
	chk_b_gating: assert property ((!cfg.fall_through && (b_s2_r.select_n || !b_s2_r.qualify)) |=> $stable(rd_ptr_r))
		else $error("port b read while not selected");
	// a read in the same cycle may clear full, so full must hold only without a port b edge
	chk_no_overflow: assert property (full && a_wr |=> $stable(wr_ptr_r) && (full || $past(b_rd) || $past(b_edge)))
		else $error("write into full fifo");
	chk_std_empty: assert property (b_edge && !cfg.fall_through && occ == '0 |=> !empty_outvalid_flag)
		else $error("empty flag high on empty fifo");
	chk_fall_through_mode_ready: assert property (b_edge && cfg.fall_through |=> empty_outvalid_flag == $past(stage_v_r))
		else $error("output ready does not follow staged word");
	chk_lane_bound: assert property (lane_r <= last_lane || $changed(last_lane))
		else $error("lane index beyond port b width");

	cov_write_full: cover property (a_wr && full);
	cov_fall_through_mode_fall: cover property (cfg.fall_through && b_edge && !stage_v_r && mem_cnt != '0);
	cov_byte_read: cover property (b_rd && last_lane == LAST_BYTE && lane_r == 2'h3);
	cov_big_word: cover property (b_rd && cfg.big_endian && last_lane == LAST_WORD);
endmodule

// ### shared/fifo_port_pkg.sv
// constants, field layouts and carriers shared by the port-side fifo logic
package fifo_port_pkg;
	// data path
	localparam int DATA_W = 36;
	localparam int DEPTH = 1024;
	localparam int PTR_W = $clog2(DEPTH) + 1;
	localparam int BYTE_W = 9;
	localparam int HALF_W = 18;

	// lane counts expressed as index of the last lane
	localparam logic [1:0] LAST_LONG = 2'h0;
	localparam logic [1:0] LAST_WORD = 2'h1;
	localparam logic [1:0] LAST_BYTE = 2'h3;

	// software register bus
	localparam int REG_ADDR_W = 4;
	localparam int REG_DATA_W = 32;
	localparam logic [REG_ADDR_W-1:0] OFS_AE_OFFSET = 4'h0;
	localparam logic [REG_ADDR_W-1:0] OFS_AF_THRESH = 4'h4;
	localparam logic [REG_ADDR_W-1:0] OFS_CONFIG = 4'h8;
	localparam logic [REG_ADDR_W-1:0] OFS_STATUS = 4'hc;

	// reset values of the flag thresholds
	localparam logic [PTR_W-1:0] RST_AE_OFFSET = 11'h008;
	localparam logic [PTR_W-1:0] RST_AF_THRESH = 11'h008;

	// config register field positions
	localparam int CFG_BIG_POS = 0;
	localparam int CFG_FALL_THROUGH_MODE_POS = 1;
	localparam int CFG_NARROW_POS = 2;
	localparam int CFG_MATCH_POS = 3;

	// status register field positions
	localparam int STS_COUNT_POS = 0;
	localparam int STS_STAGE_POS = 16;
	localparam int STS_FULL_POS = 17;

	// control pins of one port, as seen after synchronisation
	typedef struct packed {
		logic clock;
		logic select_n;
		logic qualify;
		logic write;
	} port_ctl_t;

	// port b arrangement chosen from the straps
	typedef struct packed {
		logic big_endian;
		logic fall_through;
		logic narrow;
		logic match;
	} port_cfg_t;
endpackage

// ### sim/port_pair_model.sv
// far-side model: free-running port clocks, port a writer, port b reader
module port_pair_model
	import fifo_port_pkg::*;
(
	// clock
	input wire logic core_clk,
	// port a pins
	output logic a_clk,
	output logic a_sel_n,
	output logic a_qual,
	output logic a_wr,
	output logic [fifo_port_pkg::DATA_W-1:0] a_data,
	// port b pins
	output logic b_clk,
	output logic b_sel_n,
	output logic b_qual,
	// port b lane settled
	output logic lane_ok
);
	logic [2:0] div_r;

	initial begin
		div_r = 3'h0;
		a_clk = 1'b0;
		b_clk = 1'b0;
		a_sel_n = 1'b1;
		a_qual = 1'b0;
		a_wr = 1'b0;
		a_data = '0;
		b_sel_n = 1'b1;
		b_qual = 1'b0;
		lane_ok = 1'b0;
	end

	// half period of 4 core cycles, b leads a by 2 so edges never coincide with sync stages
	always @(posedge core_clk) begin
		div_r <= div_r + 3'h1;
		a_clk <= div_r[2];
		b_clk <= div_r[2] ^ div_r[1];
	end

	// held from falling edge to falling edge around one rising edge
	task automatic write_a(input logic [DATA_W-1:0] w, input logic q);
		@(negedge a_clk);
		a_sel_n <= 1'b0;
		a_qual <= q;
		a_wr <= 1'b1;
		a_data <= w;
		@(negedge a_clk);
		a_sel_n <= 1'b1;
		a_qual <= 1'b0;
		a_wr <= 1'b0;
		a_data <= ~w;
	endtask

	// rd low only waits one b cycle, for a fall-through peek; look low skips the compare
	task automatic read_b(input logic rd, input logic look);
		@(negedge b_clk);
		b_sel_n <= ~rd;
		b_qual <= rd;
		@(negedge b_clk);
		b_sel_n <= 1'b1;
		b_qual <= 1'b0;
		repeat (2) @(posedge core_clk);
		lane_ok <= look;
		@(posedge core_clk);
		lane_ok <= 1'b0;
	endtask
endmodule

// ### sim/test_bus_matching_fifo_port_flags.sv
// self-checking bench for port gating, flags and port b sizing
module test_bus_matching_fifo_port_flags;
	timeunit 1ns;
	timeprecision 1ps;
	import fifo_port_pkg::*;
	logic core_clk, arst_n, strap, match, narrow, reg_write, reg_read, rd_d;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic a_clk, a_sel_n, a_qual, a_wr, b_clk, b_sel_n, b_qual, lane_ok;
	logic [35:0] a_data, a_bus, a_out, b_out;
	logic a_oe, b_oe, full_f, af_n, empty_f, ae_n;
	logic [35:0] lane_q[$];
	logic [31:0] reg_q[$];
	int n_mismatch, checks;
	integer seed;

	// wire level from both parties on port a
	assign a_bus = a_oe ? a_out : a_data;

	fifo_port_flags dut_u (.core_clk(core_clk), .arst_n(arst_n),
		.port_a_clock(a_clk), .port_a_select_n(a_sel_n), .port_a_qualify(a_qual), .port_a_write(a_wr),
		.port_a_data_i(a_bus), .port_a_data_o(a_out), .port_a_data_oe(a_oe),
		.full_inready_flag(full_f), .almost_full_n(af_n),
		.port_b_clock(b_clk), .port_b_select_n(b_sel_n), .port_b_qualify(b_qual), .port_b_write(1'b0),
		.port_b_data_i(36'h0), .port_b_data_o(b_out), .port_b_data_oe(b_oe),
		.empty_outvalid_flag(empty_f), .almost_empty_n(ae_n),
		.endian_or_timing_select(strap), .bus_width_match(match), .narrow_width_select(narrow),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata));

	port_pair_model partner_u (.core_clk(core_clk), .a_clk(a_clk), .a_sel_n(a_sel_n), .a_qual(a_qual),
		.a_wr(a_wr), .a_data(a_data), .b_clk(b_clk), .b_sel_n(b_sel_n), .b_qual(b_qual), .lane_ok(lane_ok));

	task automatic cmp(input string what, input logic [35:0] exp, input logic [35:0] got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge core_clk);
		reg_write <= 1'b0;
	endtask

	task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		reg_q.push_back(e);
		@(posedge core_clk);
		reg_read <= 1'b0;
	endtask

	// lanes of one word in the order port b must show them
	task automatic expect_word(input logic [35:0] w, input int n, input logic big);
		int lw;
		lw = 36 / n;
		for (int i = 0; i < n; i++)
			lane_q.push_back((w >> (lw * (big ? n - 1 - i : i))) & ((36'h1 << lw) - 36'h1));
	endtask

	// watcher: results are matched against the oldest note
	always @(posedge core_clk) begin
		rd_d <= reg_read;
		if (rd_d)
			cmp("reg_rdata", 36'(reg_q.pop_front()), 36'(reg_rdata));
		if (lane_ok)
			cmp("port_b_data", lane_q.pop_front(), b_out);
	end

	task automatic run(input logic big, input logic ft, input logic nar, input logic mat, input int nw);
		logic [35:0] w;
		int n;
		n = !mat ? 1 : nar ? 4 : 2;
		@(posedge core_clk);
		arst_n <= 1'b0;
		strap <= big;
		narrow <= nar;
		match <= mat;
		repeat (4) @(posedge core_clk);
		arst_n <= 1'b1;
		repeat (6) @(posedge core_clk);
		strap <= ~ft;
		repeat (6) @(posedge core_clk);
		reg_rd(OFS_CONFIG, {28'h0, mat, nar, ft, big});
		reg_rd(OFS_AE_OFFSET, 32'h8);
		reg_rd(OFS_AF_THRESH, 32'h8);
		reg_rd(4'h2, 32'h0);
		reg_wr(OFS_CONFIG, 32'h0);
		reg_rd(OFS_CONFIG, {28'h0, mat, nar, ft, big});
		reg_wr(OFS_AE_OFFSET, 32'(nw - 1));
		// a staged fall-through word has left the memory and frees a location
		reg_wr(OFS_AF_THRESH, 32'(DEPTH - nw + int'(ft)));
		partner_u.write_a(36'h5a5a5a5a5, 1'b0);
		repeat (24) @(posedge core_clk);
		cmp("empty_outvalid_flag", 36'h0, 36'(empty_f));
		for (int i = 0; i < nw; i++) begin
			w = 36'({$random(seed), $random(seed)});
			partner_u.write_a(w, 1'b1);
			expect_word(w, n, big);
		end
		// a word offered while full must be dropped
		if (nw == DEPTH)
			partner_u.write_a(36'h0, 1'b1);
		repeat (24) @(posedge core_clk);
		cmp("full_inready_flag", 36'(nw != DEPTH), 36'(full_f));
		cmp("almost_full_n", 36'h0, 36'(af_n));
		cmp("almost_empty_n", 36'h1, 36'(ae_n));
		cmp("empty_outvalid_flag", 36'h1, 36'(empty_f));
		cmp("port_a_data_oe", 36'h0, 36'(a_oe));
		cmp("port_b_data_oe", 36'h0, 36'(b_oe));
		if (ft)
			partner_u.read_b(1'b0, 1'b1);
		for (int i = ft; i < n * nw; i++)
			partner_u.read_b(1'b1, 1'b1);
		// in fall-through the last lane stands until one more read takes it
		if (ft)
			partner_u.read_b(1'b1, 1'b0);
		repeat (24) @(posedge core_clk);
		cmp("empty_outvalid_flag", 36'h0, 36'(empty_f));
		cmp("almost_empty_n", 36'h0, 36'(ae_n));
		cmp("almost_full_n", 36'h1, 36'(af_n));
		$display("test done big %0d fall %0d narrow %0d match %0d", big, ft, nar, mat);
	endtask

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// whole run is about 34k cycles; over twice that means a hang
	initial begin
		#800us;
		n_mismatch++;
		results();
	end

	initial begin
		seed = 32'h9b8b;
		n_mismatch = 0;
		checks = 0;
		arst_n = 1'b0;
		strap = 1'b0;
		match = 1'b0;
		narrow = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		reg_write = 1'b0;
		reg_read = 1'b0;
		rd_d = 1'b0;
		run(1'b0, 1'b0, 1'b0, 1'b0, DEPTH);
		run(1'b1, 1'b1, 1'b1, 1'b1, 3);
		run(1'b0, 1'b0, 1'b0, 1'b1, 3);
		run(1'b1, 1'b1, 1'b0, 1'b1, 2);
		run(1'b0, 1'b1, 1'b1, 1'b1, 2);
		results();
	end
endmodule
